// >>> hw/tsic_flag_bank.sv
/*
 * tsic_flag_bank: sticky interrupt flags, set by one-cycle events, cleared by software.
 * Assumes set and clear are one-cycle pulses synchronous to core_clk.
 */
`timescale 1ns/1ps
module tsic_flag_bank
(
	input  wire logic core_clk,
	input  wire logic nrst,
	tsic_flag_if.bank fl
);
	import tsic_pkg::*;

	logic [23:0] flag_ff;
	logic [23:0] nxt_flag;

	// an event in the clearing cycle wins so no event is lost
	always_comb
	begin
		nxt_flag = ((flag_ff & ~fl.clr) | fl.set_ev) & SRC_VALID;
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			flag_ff <= RST_SRC;
		else
			flag_ff <= nxt_flag;
	end

	assign fl.flags = flag_ff;
endmodule // tsic_flag_bank

// >>> hw/tsic_flag_if.sv
/*
 * tsic_flag_if: event, clear and flag vectors between the control block and its flag bank.
 * Assumes both ends run on core_clk.
 */
`timescale 1ns/1ps
interface tsic_flag_if;
	logic [23:0] set_ev;
	logic [23:0] clr;
	logic [23:0] flags;

	modport bank (input set_ev, input clr, output flags);
	modport user (output set_ev, output clr, input flags);
endinterface

// >>> hw/tsic_irq_ctrl.sv
/*
 * tsic_irq_ctrl: interrupt enable, mask and status logic of the transport-stream
 * interface, with an AHB-Lite register slave and one level interrupt output.
 * Assumes all event inputs are synchronous to core_clk; one slave on the bus so
 * hreadyout is the bus hready.
 */
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module tsic_irq_ctrl
#(
	parameter int STC_W   = 32,
	parameter int RING_AW = 32
)
(
	input  wire logic                           core_clk,
	input  wire logic                           nrst,
	// ahb-lite slave
	input  wire logic                           hsel,
	input  wire logic [31:0]                    haddr,
	input  wire logic [1:0]                     htrans,
	input  wire logic                           hwrite,
	input  wire logic [2:0]                     hsize,
	input  wire logic [31:0]                    hwdata,
	input  wire logic                           hready,
	output logic                                hreadyout,
	output logic [31:0]                         hrdata,
	output logic                                hresp,
	// system time clock compare
	input  wire logic [STC_W-1:0]               stc_count,
	input  wire logic [tsic_pkg::NUM_CH*STC_W-1:0]   clock_compare_entry,
	// write ring buffers
	input  wire logic [tsic_pkg::NUM_CH*RING_AW-1:0] wring_addr,
	input  wire logic [tsic_pkg::NUM_CH*RING_AW-1:0] write_ring_threshold_pointer,
	// read ring buffer channel 0
	input  wire logic [RING_AW-1:0]             rring_addr,
	input  wire logic [RING_AW-1:0]             read_ring_threshold_pointer,
	// received packet header and stream events, one-cycle pulses
	input  wire logic                           pkt_hdr_valid,
	input  wire logic                           pkt_unit_start,
	input  wire logic                           pkt_priority,
	input  wire logic                           pkt_error_ev,
	input  wire logic                           program_map_ev,
	input  wire logic                           program_assoc_ev,
	input  wire logic                           boundary_ev,
	// interrupt to the processor core
	output logic                                irq
);
	import tsic_pkg::*;

	// reached test of the system time clock comparators; the ring comparators use reached_ring
	function automatic logic reached_stc(input logic [STC_W-1:0] cnt,
	                                     input logic [STC_W-1:0] cmp);
		reached_stc = (cnt == cmp);
	endfunction

	function automatic logic reached_ring(input logic [RING_AW-1:0] addr,
	                                      input logic [RING_AW-1:0] ptr);
		reached_ring = (addr == ptr);
	endfunction

	tsic_flag_if fl ();

	tsic_flag_bank u_flag_bank
	(
		.core_clk (core_clk),
		.nrst     (nrst),
		.fl       (fl)
	);

	// registers
	logic [23:0]     pri_en_ff;
	logic [23:0]     nxt_pri_en;
	logic [23:0]     sec_en_ff;
	logic [23:0]     nxt_sec_en;
	logic [23:0]     mask_ff;
	logic [23:0]     nxt_mask;
	logic            global_en_ff;
	logic            nxt_global_en;
	logic [23:0]     match_ff;
	logic [23:0]     nxt_match;
	logic            irq_ff;
	logic            nxt_irq;
	// bus state
	tsic_bus_state_t bus_state_ff;
	tsic_bus_state_t nxt_bus_state;
	logic            wr_pend_ff;
	logic            nxt_wr_pend;
	logic [11:0]     addr_ff;
	logic [11:0]     nxt_addr;
	logic [31:0]     hrdata_ff;
	logic [31:0]     nxt_hrdata;
	logic            hready_ff;
	logic            nxt_hready;
	// decoded strobes
	logic            addr_take;
	logic            wr_pri;
	logic            wr_sec;
	logic            wr_mask;
	logic            wr_clr;
	logic            wr_ctrl;
	logic [23:0]     wdata_src;
	logic [23:0]     match_now;
	logic [23:0]     src_ev;
	logic [23:0]     path_open;

	// threshold comparators, one per compare entry and write ring channel
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_cmp
			assign match_now[POS_STC + g]   = reached_stc(stc_count,
				clock_compare_entry[g*STC_W +: STC_W]);
			assign match_now[POS_WRING + g] = reached_ring(wring_addr[g*RING_AW +: RING_AW],
				write_ring_threshold_pointer[g*RING_AW +: RING_AW]);
		end
	endgenerate

	// low sources: only the read ring compares, 7 and 5 are reserved, the rest are pulse-driven;
	// plain assigns here, since the generate above already drives the high bits
	assign match_now[7:5]       = 3'b000;
	assign match_now[POS_RRING] = reached_ring(rring_addr,
		read_ring_threshold_pointer);
	assign match_now[3:0]       = 4'h0;

	// a flag fires on the cycle a threshold is first reached; a counter that
	// parks on its threshold would otherwise re-raise a flag right after clearing
	always_comb
	begin
		nxt_match = match_now;
		src_ev    = match_now & ~match_ff;
		src_ev[POS_PKT_ERR]  = pkt_error_ev;
		src_ev[POS_PMT]      = program_map_ev;
		src_ev[POS_PAT]      = program_assoc_ev;
		src_ev[POS_GOP]      = pkt_hdr_valid & pkt_unit_start & pkt_priority;
		src_ev[POS_BOUNDARY] = boundary_ev;
	end

	// events go straight to the flags, no enable looks at them
	assign fl.set_ev = src_ev & SRC_VALID;

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			match_ff <= RST_SRC;
		else
			match_ff <= nxt_match;
	end

	// address phase is taken only while the bus is ready
	assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);

	// write strobes in the data phase; hsize is not checked, only words are used
	always_comb
	begin
		wr_pri  = 1'b0;
		wr_sec  = 1'b0;
		wr_mask = 1'b0;
		wr_clr  = 1'b0;
		wr_ctrl = 1'b0;
		if (wr_pend_ff && addr_ff == OFF_PRI_EN)
			wr_pri = 1'b1;
		else if (wr_pend_ff && addr_ff == OFF_SEC_EN)
			wr_sec = 1'b1;
		else if (wr_pend_ff && addr_ff == OFF_MASK)
			wr_mask = 1'b1;
		else if (wr_pend_ff && addr_ff == OFF_FLAG_CLR)
			wr_clr = 1'b1;
		else if (wr_pend_ff && addr_ff == OFF_CTRL)
			wr_ctrl = 1'b1;
	end

	assign wdata_src = hwdata[23:0] & SRC_VALID;
	assign fl.clr    = wr_clr ? wdata_src : RST_SRC;

	// enable and mask state
	always_comb
	begin
		nxt_pri_en    = pri_en_ff;
		nxt_sec_en    = sec_en_ff;
		nxt_global_en = global_en_ff;
		nxt_mask      = mask_ff;
		if (wr_pri)
			nxt_pri_en = wdata_src;
		if (wr_sec)
			nxt_sec_en = wdata_src;
		if (wr_ctrl)
			nxt_global_en = hwdata[POS_GLOBAL_EN];
		// written ones mask only open paths, zeros leave the mask alone
		if (wr_mask)
			nxt_mask = mask_ff | (wdata_src & pri_en_ff & sec_en_ff);
		// writing a secondary enable bit to 1 releases its mask
		if (wr_sec)
			nxt_mask = nxt_mask & ~wdata_src;
		// a mask cannot outlive the enables it was set under
		nxt_mask = nxt_mask & nxt_pri_en & nxt_sec_en;
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			pri_en_ff    <= RST_SRC;
			sec_en_ff    <= RST_SRC;
			mask_ff      <= RST_SRC;
			global_en_ff <= RST_GLOBAL_EN;
		end
		else
		begin
			pri_en_ff    <= nxt_pri_en;
			sec_en_ff    <= nxt_sec_en;
			mask_ff      <= nxt_mask;
			global_en_ff <= nxt_global_en;
		end
	end

	// interrupt path, registered so irq comes straight from a flip-flop
	always_comb
	begin
		path_open = pri_en_ff & sec_en_ff & ~mask_ff;
		nxt_irq   = global_en_ff && |(fl.flags & path_open);
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			irq_ff <= 1'b0;
		else
			irq_ff <= nxt_irq;
	end

	// read mux: reserved bits and write-only registers read zero
	function automatic logic [31:0] rd_value(input logic [11:0] off);
		rd_value = 32'h00000000;
		if (off == OFF_PRI_EN)
			rd_value = {8'h00, pri_en_ff};
		else if (off == OFF_SEC_EN)
			rd_value = {8'h00, sec_en_ff};
		else if (off == OFF_MASK)
			rd_value = 32'h00000000;
		else if (off == OFF_FLAGS)
			rd_value = {8'h00, fl.flags};
		else if (off == OFF_CTRL)
			rd_value = {31'h00000000, global_en_ff};
	endfunction

	// reads take one wait state so a write just ahead of them is seen;
	// writes finish with no wait
	always_comb
	begin
		nxt_bus_state = bus_state_ff;
		nxt_wr_pend   = 1'b0;
		nxt_addr      = addr_ff;
		nxt_hrdata    = hrdata_ff;
		nxt_hready    = 1'b1;
		case (bus_state_ff)
			TSIC_BUS_IDLE:
			begin
				if (addr_take)
				begin
					nxt_addr = {haddr[11:2], 2'b00};
					if (hwrite)
						nxt_wr_pend = 1'b1;
					else
					begin
						nxt_bus_state = TSIC_BUS_RD_WAIT;
						nxt_hready    = 1'b0;
					end
				end
			end
			TSIC_BUS_RD_WAIT:
			begin
				nxt_hrdata    = rd_value(addr_ff);
				nxt_bus_state = TSIC_BUS_IDLE;
			end
			default:
			begin
				nxt_bus_state = TSIC_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			bus_state_ff <= TSIC_BUS_IDLE;
			wr_pend_ff   <= 1'b0;
			addr_ff      <= 12'h000;
			hrdata_ff    <= 32'h00000000;
			hready_ff    <= 1'b1;
		end
		else
		begin
			bus_state_ff <= nxt_bus_state;
			wr_pend_ff   <= nxt_wr_pend;
			addr_ff      <= nxt_addr;
			hrdata_ff    <= nxt_hrdata;
			hready_ff    <= nxt_hready;
		end
	end

	assign hreadyout = hready_ff;
	assign hrdata    = hrdata_ff;
	assign hresp     = HRESP_OKAY; // constant okay, every access completes
	assign irq       = irq_ff;
endmodule // tsic_irq_ctrl

// >>> hw/tsic_pkg.sv
/*
 * tsic_pkg: constants shared by the transport-stream interrupt control block.
 * Assumes a 32-bit AHB-Lite register bus and 24 interrupt sources.
 */
package tsic_pkg;
	localparam int          NUM_SRC       = 24;
	localparam int          NUM_CH        = 8;
	// register byte offsets
	localparam logic [11:0] OFF_PRI_EN    = 12'h000;
	localparam logic [11:0] OFF_SEC_EN    = 12'h004;
	localparam logic [11:0] OFF_MASK      = 12'h008;
	localparam logic [11:0] OFF_FLAGS     = 12'h00c;
	localparam logic [11:0] OFF_FLAG_CLR  = 12'h010;
	localparam logic [11:0] OFF_CTRL      = 12'h014;
	// field positions
	localparam int          POS_STC       = 16;
	localparam int          POS_WRING     = 8;
	localparam int          POS_PKT_ERR   = 6;
	localparam int          POS_RRING     = 4;
	localparam int          POS_PMT       = 3;
	localparam int          POS_PAT       = 2;
	localparam int          POS_GOP       = 1;
	localparam int          POS_BOUNDARY  = 0;
	localparam int          POS_GLOBAL_EN = 0;
	// implemented source bits; 7 and 5 are reserved
	localparam logic [23:0] SRC_VALID     = 24'hffff5f;
	// reset values, then bus encodings
	localparam logic [23:0] RST_SRC       = 24'h000000;
	localparam logic        RST_GLOBAL_EN = 1'b0;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic        HRESP_OKAY    = 1'b0;

	typedef enum logic {TSIC_BUS_IDLE, TSIC_BUS_RD_WAIT} tsic_bus_state_t;
endpackage

// >>> sim/testbench.sv
/* testbench: register, event and interrupt scenarios for tsic_irq_ctrl.
   Assumes the host model drives the bus while the bound checker watches it. */
`timescale 1ns/1ps
module testbench;
	import tsic_pkg::*;
	logic core_clk, nrst, hsel, hwrite, hreadyout, hresp, irq, rd_ph, tmo;
	logic [31:0] haddr, hwdata, hrdata, stc, rra, rrp, seed, r, e;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [255:0] cce, wad, wpt;
	logic hv, hu, hp, pe, pm, pa, bd;
	logic [31:0] exp_q[$];
	int failures, n_compared;

	tsic_irq_ctrl dut (.core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .stc_count(stc),
		.clock_compare_entry(cce), .wring_addr(wad), .write_ring_threshold_pointer(wpt),
		.rring_addr(rra), .read_ring_threshold_pointer(rrp), .pkt_hdr_valid(hv),
		.pkt_unit_start(hu), .pkt_priority(hp), .pkt_error_ev(pe), .program_map_ev(pm),
		.program_assoc_ev(pa), .boundary_ev(bd), .irq(irq));
	tsic_host_model host (.core_clk(core_clk), .hready(hreadyout), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.rd_ph(rd_ph), .tmo(tmo));

	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x)
		begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, g, x);
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		exp_q.push_back(x);
		host.xfer(1'b0, a, 32'h0);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d);
	endtask
	// one-cycle event strobes, order hv hu hp pe pm pa bd
	task automatic pulse(input logic [6:0] v);
		{hv, hu, hp, pe, pm, pa, bd} <= v;
		@(posedge core_clk);
		{hv, hu, hp, pe, pm, pa, bd} <= 7'h0;
		@(posedge core_clk);
	endtask
	// irq is registered two edges behind a register write
	task automatic irq_is(input logic x);
		repeat (2) @(posedge core_clk);
		chk({31'h0, irq}, {31'h0, x});
	endtask
	task automatic give_verdict();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// read results are checked against the oldest note as they complete
	always @(posedge core_clk)
		if (rd_ph === 1'b1 && hreadyout === 1'b1)
		begin
			e = exp_q.pop_front();
			chk(hrdata, e);
		end
	always @(posedge tmo)
	begin
		failures++;
		give_verdict();
	end

	initial
	begin
		seed = 32'h8a186b01;
		{nrst, stc, rra, cce, wad, wpt, hv, hu, hp, pe, pm, pa, bd} = '0;
		rrp = 32'h1;
		failures = 0;
		n_compared = 0;
		for (int g = 0; g < 8; g++)
		begin
			cce[g*32 +: 32] = xs() | 32'h1;
			wpt[g*32 +: 32] = xs() | 32'h1;
		end
		repeat (5) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		// reset values, then one unmapped word
		for (int i = 0; i < 7; i++)
			rd(12'(i * 4), 32'h0);
		r = xs();
		wr(OFF_SEC_EN, r);
		wr(OFF_PRI_EN, ~r);
		wr(OFF_MASK, r);
		wr(OFF_FLAGS, r);
		rd(OFF_SEC_EN, r & {8'h0, SRC_VALID});
		rd(OFF_PRI_EN, ~r & {8'h0, SRC_VALID});
		rd(OFF_MASK, 32'h0);
		rd(OFF_FLAGS, 32'h0);
		wr(OFF_PRI_EN, 32'h0);
		// events with every primary enable and the global enable closed still set flags
		pulse(7'h6f);
		rd(OFF_FLAGS, 32'h4d);
		pulse(7'h70);
		stc <= cce[7*32 +: 32];
		wad[7*32 +: 32] <= wpt[7*32 +: 32];
		@(posedge core_clk);
		rd(OFF_FLAGS, 32'h80804f);
		for (int g = 0; g < 8; g++)
		begin
			stc <= cce[g*32 +: 32];
			wad[g*32 +: 32] <= wpt[g*32 +: 32];
			@(posedge core_clk);
		end
		rra <= rrp;
		@(posedge core_clk);
		rd(OFF_FLAGS, {8'h0, SRC_VALID});
		wr(OFF_FLAG_CLR, 32'hfffffffa);
		rd(OFF_FLAGS, 32'h5);
		// enable, mask and global gating of the interrupt
		wr(OFF_SEC_EN, 32'h5);
		wr(OFF_CTRL, 32'hffffffff);
		rd(OFF_CTRL, 32'h1);
		irq_is(1'b0);
		wr(OFF_PRI_EN, 32'h1);
		irq_is(1'b1);
		wr(OFF_MASK, 32'h5);
		irq_is(1'b0);
		// a zero write must keep bit 0 masked while it is the only enabled source
		wr(OFF_MASK, 32'h0);
		irq_is(1'b0);
		wr(OFF_PRI_EN, 32'h5);
		irq_is(1'b1);
		wr(OFF_MASK, 32'h0);
		irq_is(1'b1);
		wr(OFF_SEC_EN, 32'h0);
		irq_is(1'b0);
		wr(OFF_SEC_EN, 32'h4);
		irq_is(1'b1);
		wr(OFF_CTRL, 32'h0);
		irq_is(1'b0);
		wr(OFF_CTRL, 32'h1);
		irq_is(1'b1);
		wr(OFF_FLAG_CLR, 32'h4);
		irq_is(1'b0);
		rd(OFF_FLAGS, 32'h1);
		repeat (4) @(posedge core_clk);
		give_verdict();
	end
endmodule // testbench

// >>> sim/tsic_host_model.sv
/* tsic_host_model: processor core as ahb-lite master, single word transfers.
   Assumes one slave whose hreadyout is the bus hready. */
`timescale 1ns/1ps
module tsic_host_model
(
	input  wire logic core_clk,
	input  wire logic hready,
	output logic        hsel,
	output logic [31:0] haddr,
	output logic [1:0]  htrans,
	output logic        hwrite,
	output logic [2:0]  hsize,
	output logic [31:0] hwdata,
	output logic        rd_ph,
	output logic        tmo
);
	// quiet bus at time zero
	initial
	begin
		{hsel, haddr, htrans, hwrite, hsize, hwdata, rd_ph, tmo} = '0;
	end
	// bounded wait for hready sampled at a rising edge
	task automatic wait_rdy();
		int n;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (hready !== 1'b1 && n < 64);
		if (n >= 64)
			tmo <= 1'b1;
	endtask
	// address phase, then data phase; stale address is inverted so it is never trusted
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= tsic_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= 3'h2;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		haddr <= ~{20'h0, a};
		hwrite <= ~w;
		hwdata <= d;
		rd_ph <= ~w;
		wait_rdy();
		rd_ph <= 1'b0;
	endtask
endmodule // tsic_host_model

// >>> sim/tsic_irq_ctrl_sva.sv
/* tsic_irq_sva: port-level checks of the interrupt control block.
   Assumes one clock domain and hready tied to hreadyout. */
`timescale 1ns/1ps
module tsic_irq_sva
	import tsic_pkg::*;
#(
	parameter int STC_W   = 32,
	parameter int RING_AW = 32
)
(
	input wire logic                 core_clk,
	input wire logic                 nrst,
	input wire logic                 hsel,
	input wire logic [31:0]          haddr,
	input wire logic [1:0]           htrans,
	input wire logic                 hwrite,
	input wire logic                 hready,
	input wire logic                 hreadyout,
	input wire logic [31:0]          hrdata,
	input wire logic                 hresp,
	input wire logic [STC_W-1:0]     stc_count,
	input wire logic [8*STC_W-1:0]   clock_compare_entry,
	input wire logic [8*RING_AW-1:0] wring_addr,
	input wire logic [8*RING_AW-1:0] write_ring_threshold_pointer,
	input wire logic [RING_AW-1:0]   rring_addr,
	input wire logic [RING_AW-1:0]   read_ring_threshold_pointer,
	input wire logic                 pkt_hdr_valid,
	input wire logic                 pkt_unit_start,
	input wire logic                 pkt_priority,
	input wire logic                 pkt_error_ev,
	input wire logic                 program_map_ev,
	input wire logic                 program_assoc_ev,
	input wire logic                 boundary_ev,
	input wire logic                 irq
);
	logic ev;
	logic nxt_wr_dp;
	logic wr_dp_ff;
	// any event that may set a flag; match level is looser than the design's edge detect
	always_comb
	begin
		ev = pkt_error_ev | program_map_ev | program_assoc_ev | boundary_ev;
		ev = ev | (pkt_hdr_valid & pkt_unit_start & pkt_priority);
		ev = ev | (rring_addr == read_ring_threshold_pointer);
		for (int g = 0; g < 8; g++)
			ev = ev | (stc_count == clock_compare_entry[g*STC_W +: STC_W])
				| (wring_addr[g*RING_AW +: RING_AW] == write_ring_threshold_pointer[g*RING_AW +: RING_AW]);
		nxt_wr_dp = hsel & hready & htrans[1] & hwrite;
	end
	// write data phase marker; enables, mask and control only move on writes
	always_ff @(posedge core_clk)
		wr_dp_ff <= nrst ? nxt_wr_dp : 1'b0;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence s_rd; hsel && hready && htrans[1] && !hwrite; endsequence
	sequence s_wr; hsel && hready && htrans[1] && hwrite; endsequence
	sequence s_rd_mask; s_rd ##0 (haddr[11:2] == OFF_MASK[11:2]); endsequence
	sequence s_one_wait; !hreadyout ##1 hreadyout; endsequence

	a_resp_okay: assert property (hresp == HRESP_OKAY) else $error("response not okay");
	a_read_wait: assert property (s_rd |=> s_one_wait) else $error("read wait wrong");
	a_write_nowait: assert property (s_wr |=> hreadyout) else $error("write stalled");
	a_single_wait: assert property (!hreadyout |=> hreadyout) else $error("wait too long");
	a_hold_rdata: assert property (!$rose(hreadyout) |-> $stable(hrdata))
		else $error("read data moved");
	a_mask_reads_zero: assert property (s_rd_mask |=> ##1 hrdata == 32'h0)
		else $error("mask readable");
	a_rsvd_read_zero: assert property ($rose(hreadyout) |-> hrdata[31:24] == 8'h0
		&& hrdata[7] == 1'b0 && hrdata[5] == 1'b0) else $error("reserved bit set");
	// flag and enables move one edge after the cause, irq one edge later still
	a_irq_rise_cause: assert property ($rose(irq) |-> $past(ev, 2)
		|| $past(wr_dp_ff, 2)) else $error("irq without cause");
	a_irq_fall_cause: assert property ($fell(irq) |-> $past(wr_dp_ff, 2))
		else $error("irq dropped alone");
endmodule // tsic_irq_sva

bind tsic_irq_ctrl tsic_irq_sva #(.STC_W(STC_W), .RING_AW(RING_AW)) u_sva (
	.core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
	.stc_count(stc_count), .clock_compare_entry(clock_compare_entry),
	.wring_addr(wring_addr), .write_ring_threshold_pointer(write_ring_threshold_pointer),
	.rring_addr(rring_addr), .read_ring_threshold_pointer(read_ring_threshold_pointer),
	.pkt_hdr_valid(pkt_hdr_valid), .pkt_unit_start(pkt_unit_start),
	.pkt_priority(pkt_priority), .pkt_error_ev(pkt_error_ev),
	.program_map_ev(program_map_ev), .program_assoc_ev(program_assoc_ev),
	.boundary_ev(boundary_ev), .irq(irq));
